//--- rtl/tcd_decoder.sv
/*
  Tape command decoder and sequencer: activate word decode, rewind
  tracking, list fetch handshake, read/write/skip/erase/end-of-file
  sequencing and interrupt-then-status ordering.
  Assumes a block-transfer section on the same clock that writes list
  and data words over the register port and acknowledges status stores;
  tape pins are asynchronous and pass the synchroniser.
*/
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module tcd_decoder import tcd_pkg::*; #(
  parameter int ERASE_CYC = ERASE_CYC_DEF,
  parameter int CW = WORD_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire tcd_tape_in_t tape_i,
  output tcd_tape_out_t tape_o,
  output logic [2:0] rewind_o,
  output logic [2:0] unload_o,
  output logic list_req_o,
  output logic [15:0] list_addr_o,
  output logic data_req_o,
  output logic [15:0] mem_word_o,
  output logic mem_wr_o,
  output logic irq_o,
  output logic status_req_o,
  output logic [15:0] status_o,
  input wire logic status_ack_i,
  output logic busy_o
);

  function automatic logic [1:0] sel_unit(input logic [1:0] sel);
    sel_unit = (sel == SEL_T1) ? 2'h0 : (sel == SEL_T2) ? 2'h1 : 2'h2;
  endfunction

  function automatic logic [2:0] unit_mask(input logic [1:0] u);
    unit_mask = 3'h1 << u;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pin inputs and register strobes.

  tcd_tape_in_t tin;
  logic stb_q;
  logic gap_q;
  logic mark_q;
  logic [2:0] sot_q;

  tcd_sync #(.W($bits(tcd_tape_in_t))) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(tape_i),
    .q_o(tin)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stb_q <= 1'b0;
      gap_q <= 1'b0;
      mark_q <= 1'b0;
      sot_q <= '0;
    end else if (ce_i) begin
      stb_q <= tin.stb;
      gap_q <= tin.gap;
      mark_q <= tin.mark;
      sot_q <= tin.sot;
    end
  end

  logic stb_rise;
  logic gap_rise;
  logic mark_rise;
  logic [2:0] sot_rise;
  assign stb_rise = tin.stb & ~stb_q;
  assign gap_rise = tin.gap & ~gap_q;
  assign mark_rise = tin.mark & ~mark_q;
  assign sot_rise = tin.sot & ~sot_q;

  tcd_state_t state;
  logic act_wr;
  logic clear;
  logic cmd_ok;
  logic lw3_wr;
  logic data_wr;
  tcd_fn_t fn;
  logic [1:0] sel;
  assign act_wr = ce_i & wr_i & (addr_i == REG_ACT1);
  assign sel = {wdata_i[AW_SEL_HI], wdata_i[AW_SEL_LO]};
  assign fn = tcd_fn_t'({wdata_i[AW_FN_HI], wdata_i[AW_FN_LO]});
  assign clear = act_wr & (sel == SEL_CLEAR);
  assign cmd_ok = act_wr & ~clear & (state == ST_IDLE);
  assign lw3_wr = ce_i & wr_i & (addr_i == REG_LW3);
  assign data_wr = ce_i & wr_i & (addr_i == REG_DATA);

  //////////////////////////////////////////////////////////////////////
  // Register port. List words are written by the block-transfer section.

  logic [15:0] lw_addr;
  logic [CW-1:0] lw_cnt;
  logic [15:0] lw_par;
  logic [15:0] dword;
  logic [CW-1:0] cnt;
  logic [2:0] rewinding;
  logic [2:0] rw_done;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lw_addr <= '0;
      lw_cnt <= '0;
      lw_par <= '0;
      list_addr_o <= '0;
      dword <= '0;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        REG_LW1: lw_addr <= wdata_i;
        REG_LW2: lw_cnt <= CW'(wdata_i);
        REG_LW3: lw_par <= wdata_i;
        REG_LW4: list_addr_o <= wdata_i;
        REG_DATA: dword <= wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= '0;
      if (rd_i) begin
        case (addr_i)
          REG_ACT1: rdata_o <= {state, rewinding, rw_done, 6'h00, busy_o};
          REG_LW1: rdata_o <= lw_addr;
          REG_LW2: rdata_o <= 16'(lw_cnt);
          REG_LW3: rdata_o <= lw_par;
          REG_LW4: rdata_o <= list_addr_o;
          REG_CNT: rdata_o <= 16'(cnt);
          default: rdata_o <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Rewind tracking per transport. Transports keep rewinding after a
  // clear; the tracking and the pending reports are both dropped.

  logic [2:0] rw_quiet;
  logic [2:0] rw_unl;
  logic rw_take;
  logic [1:0] rw_pick;
  assign rw_pick = rw_done[0] ? 2'h0 : rw_done[1] ? 2'h1 : 2'h2;
  assign rw_take = ce_i & (state == ST_IDLE) & ~act_wr & (|rw_done);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rewinding <= '0;
      rw_quiet <= '0;
      rw_unl <= '0;
      rw_done <= '0;
      rewind_o <= '0;
      unload_o <= '0;
    end else if (ce_i) begin
      rewind_o <= '0;
      unload_o <= '0;
      if (clear) begin
        rewinding <= '0;
        rw_done <= '0;
      end else begin
        if (rw_take) begin
          rw_done[rw_pick] <= 1'b0;
        end
        for (int u = 0; u < 3; u++) begin
          if (rewinding[u] && sot_rise[u]) begin
            rewinding[u] <= 1'b0;
            unload_o[u] <= rw_unl[u];
            if (!rw_unl[u]) begin
              rw_done[u] <= 1'b1;
            end
          end
        end
        if (cmd_ok && fn != FN_LIST) begin
          rewinding <= rewinding | unit_mask(sel_unit(sel));
          rewind_o <= unit_mask(sel_unit(sel));
          rw_quiet[sel_unit(sel)] <= (fn == FN_RW_QUIET);
          rw_unl[sel_unit(sel)] <= (fn == FN_RW_UNLOAD);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Operation sequencer.

  tcd_sub_t op;
  logic want_irq;
  logic dvalid;
  logic half;
  logic [7:0] hi_char;
  logic [31:0] timer;
  logic run_done;
  logic chain;
  assign chain = lw_par[L3_CHAIN] & (op inside {SUB_READ, SUB_SKIP, SUB_WRITE, SUB_ERASE,
    SUB_WEOF});

  always_comb begin
    case (op)
      SUB_READ: run_done = (cnt == '0) | gap_rise | mark_rise
        | (stb_rise & (cnt == CW'(1)));
      SUB_WRITE: run_done = (cnt == '0)
        | (stb_rise & dvalid & (cnt == CW'(1)));
      SUB_SKIP: run_done = gap_rise | mark_rise;
      SUB_ERASE: run_done = (timer == '0);
      SUB_WEOF: run_done = (timer == '0);
      default: run_done = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      op <= SUB_NOP;
      want_irq <= 1'b0;
      dvalid <= 1'b0;
      half <= 1'b0;
      hi_char <= '0;
      timer <= '0;
      cnt <= '0;
      tape_o <= '0;
      list_req_o <= 1'b0;
      mem_word_o <= '0;
      mem_wr_o <= 1'b0;
      irq_o <= 1'b0;
      status_req_o <= 1'b0;
      status_o <= '0;
    end else if (ce_i) begin
      mem_wr_o <= 1'b0;
      irq_o <= 1'b0;
      tape_o.wstb <= 1'b0;
      if (data_wr) begin
        dvalid <= 1'b1;
      end
      if (clear) begin
        state <= ST_IDLE;
        list_req_o <= 1'b0;
        status_req_o <= 1'b0;
        dvalid <= 1'b0;
        tape_o <= '0;
      end else begin
        case (state)
          ST_IDLE: begin
            status_o <= '0;
            if (cmd_ok) begin
              tape_o.unit <= sel_unit(sel);
              if (fn == FN_LIST) begin
                list_req_o <= 1'b1;
                state <= ST_FETCH;
              end else begin
                status_o[ST_OC] <= 1'b1;
                want_irq <= (fn != FN_RW_QUIET);
                state <= (fn != FN_RW_QUIET) ? ST_IRQ : ST_STAT;
                status_req_o <= (fn == FN_RW_QUIET);
              end
            end else if (rw_take) begin
              status_o[ST_RW_BASE - 32'(rw_pick)] <= 1'b1;
              state <= rw_quiet[rw_pick] ? ST_STAT : ST_IRQ;
              status_req_o <= rw_quiet[rw_pick];
            end
          end
          ST_FETCH: begin
            if (lw3_wr) begin
              list_req_o <= 1'b0;
              op <= tcd_sub_t'(wdata_i[L3_SUB_HI:L3_SUB_LO]);
              want_irq <= wdata_i[L3_INT];
              cnt <= lw_cnt;
              half <= 1'b0;
              timer <= 32'(ERASE_CYC - 1);
              tape_o.motion <= 1'b1;
              tape_o.erase <= (wdata_i[L3_SUB_HI:L3_SUB_LO] == SUB_ERASE)
                | (wdata_i[L3_SUB_HI:L3_SUB_LO] == SUB_WEOF);
              tape_o.dir <= (wdata_i[L3_SUB_HI:L3_SUB_LO] == SUB_SKIP)
                & wdata_i[L3_DIR];
              state <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (op == SUB_READ && stb_rise && cnt != '0) begin
              cnt <= cnt - CW'(1);
              if (!half) begin
                hi_char <= tin.chr;
                half <= 1'b1;
                mem_word_o <= {tin.chr, PAD_CHAR};
                mem_wr_o <= (cnt == CW'(1));
              end else begin
                mem_word_o <= {hi_char, tin.chr};
                mem_wr_o <= 1'b1;
                half <= 1'b0;
              end
            end else if (op == SUB_READ && gap_rise && half) begin
              mem_word_o <= {hi_char, PAD_CHAR};
              mem_wr_o <= 1'b1;
            end
            if (op == SUB_WRITE && stb_rise && dvalid && cnt != '0) begin
              tape_o.wchr <= half ? dword[7:0] : dword[15:8];
              tape_o.wstb <= 1'b1;
              cnt <= cnt - CW'(1);
              half <= ~half;
              if ((half || cnt == CW'(1)) && !data_wr) begin
                dvalid <= 1'b0;
              end
            end
            if ((op == SUB_ERASE || op == SUB_WEOF) && timer != '0) begin
              timer <= timer - 32'd1;
            end
            if (op == SUB_WEOF && timer == '0) begin
              tape_o.wchr <= EOF_CHAR;
              tape_o.wstb <= 1'b1;
            end
            if (run_done) begin
              tape_o.motion <= 1'b0;
              tape_o.erase <= 1'b0;
              if (chain) begin
                list_req_o <= 1'b1;
                state <= ST_FETCH;
              end else begin
                status_o[ST_OC] <= 1'b1;
                status_o[ST_EOF] <= mark_rise;
                state <= want_irq ? ST_IRQ : ST_STAT;
                status_req_o <= ~want_irq;
              end
            end
          end
          ST_IRQ: begin
            irq_o <= 1'b1;
            status_req_o <= 1'b1;
            state <= ST_STAT;
          end
          ST_STAT: begin
            if (status_ack_i) begin
              status_req_o <= 1'b0;
              state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      data_req_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= (state != ST_IDLE);
      data_req_o <= (state == ST_RUN) & (op == SUB_WRITE) & ~dvalid;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  clear_to_idle_a: assert property (clear |=> state == ST_IDLE && !status_req_o)
    else $error("clear did not return to idle");
  busy_ignores_cmd_a: assert property (
    act_wr && !clear && state != ST_IDLE |=> rewind_o == 3'h0)
    else $error("command accepted while busy");
  unit_select_a: assert property (
    cmd_ok && fn != FN_LIST && sel == SEL_T2 |=> rewind_o == 3'h2)
    else $error("wrong transport selected");
  irq_rewind_a: assert property (
    cmd_ok && fn == FN_RW_INT |=> state == ST_IRQ ##1 irq_o && status_req_o)
    else $error("rewind interrupt not before status");
  quiet_rewind_a: assert property (
    cmd_ok && fn == FN_RW_QUIET |=> state == ST_STAT ##0 !irq_o [*2])
    else $error("quiet rewind raised interrupt");
  status_hold_a: assert property (
    ce_i && state == ST_STAT && !status_ack_i && !clear |=> state == ST_STAT && busy_o)
    else $error("left status store before acknowledge");
  zero_count_a: assert property (
    ce_i && !clear && state == ST_RUN && op == SUB_WRITE && cnt == '0 |=> !tape_o.wstb)
    else $error("character written for zero count");
  odd_read_a: assert property (
    ce_i && !clear && state == ST_RUN && op == SUB_READ && stb_rise && !half
    && cnt == CW'(1) |=> mem_wr_o && mem_word_o[7:0] == PAD_CHAR)
    else $error("odd read not padded with ones");
  eof_char_a: assert property (
    ce_i && !clear && state == ST_RUN && op == SUB_WEOF && timer == '0
    |=> tape_o.wstb && tape_o.wchr == EOF_CHAR)
    else $error("end-of-file code not written");

  rewind_path_c: cover property (cmd_ok && fn == FN_RW_INT ##[1:20] status_ack_i);
  list_read_c: cover property (lw3_wr && state == ST_FETCH ##[1:200] mem_wr_o);
  clear_busy_c: cover property (clear && state == ST_RUN);

endmodule

//--- rtl/tcd_pkg.sv
/*
  Shared constants and types of the tape command decoder: activate and
  list word fields, register offsets, function and subcommand codes,
  status bit positions and the erase timing.
  Assumes 16-bit words whose bit 0 is the most significant bit, so that
  printed bit n of a word is vector index 15-n.
*/
package tcd_pkg;

  localparam int WORD_W = 16;

  // Activate word 1 fields (vector indices).
  localparam int AW_FN_HI = 7;
  localparam int AW_FN_LO = 6;
  localparam int AW_SEL_HI = 4;
  localparam int AW_SEL_LO = 3;

  // List word 3 fields (vector indices).
  localparam int L3_INT = 15;
  localparam int L3_DIR = 14;
  localparam int L3_CHAIN = 13;
  localparam int L3_SUB_HI = 12;
  localparam int L3_SUB_LO = 10;

  // Status word 1 bits (vector indices).
  localparam int ST_OC = 15;
  localparam int ST_EOF = 8;
  localparam int ST_RW_BASE = 4;

  // Register offsets.
  localparam logic [2:0] REG_ACT1 = 3'h0;
  localparam logic [2:0] REG_LW1 = 3'h1;
  localparam logic [2:0] REG_LW2 = 3'h2;
  localparam logic [2:0] REG_LW3 = 3'h3;
  localparam logic [2:0] REG_LW4 = 3'h4;
  localparam logic [2:0] REG_DATA = 3'h5;
  localparam logic [2:0] REG_CNT = 3'h6;

  localparam logic [1:0] SEL_CLEAR = 2'h0;
  localparam logic [1:0] SEL_T1 = 2'h1;
  localparam logic [1:0] SEL_T2 = 2'h2;
  localparam logic [7:0] EOF_CHAR = 8'h13;
  localparam logic [7:0] PAD_CHAR = 8'hff;

  // Erase length over tape speed, rounded up to whole clock cycles.
  localparam longint CLK_HZ = 200000000;
  localparam longint ERASE_UM = 88900;
  localparam longint TAPE_UM_PER_S = 952500;
  localparam int ERASE_CYC_DEF =
    int'((ERASE_UM * CLK_HZ + TAPE_UM_PER_S - 1) / TAPE_UM_PER_S);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_RUN = 3'h3,
    ST_IRQ = 3'h2,
    ST_STAT = 3'h6
  } tcd_state_t;

  typedef enum logic [1:0] {
    FN_RW_INT = 2'h0,
    FN_RW_UNLOAD = 2'h1,
    FN_RW_QUIET = 2'h2,
    FN_LIST = 2'h3
  } tcd_fn_t;

  typedef enum logic [2:0] {
    SUB_READ = 3'h0,
    SUB_SKIP = 3'h1,
    SUB_NOP = 3'h2,
    SUB_WRITE = 3'h4,
    SUB_ERASE = 3'h5,
    SUB_WEOF = 3'h6
  } tcd_sub_t;

  typedef struct packed {
    logic [7:0] chr;
    logic stb;
    logic gap;
    logic mark;
    logic [2:0] sot;
  } tcd_tape_in_t;

  typedef struct packed {
    logic [1:0] unit;
    logic motion;
    logic dir;
    logic erase;
    logic [7:0] wchr;
    logic wstb;
  } tcd_tape_out_t;

endpackage

//--- rtl/tcd_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes a single clock; inputs may change at any time.
*/
`timescale 1ns/1ps
module tcd_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce_i) begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes only once the last two stages agree.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        q_o[i] <= 1'b0;
      end else if (ce_i && (s2[i] == s3[i])) begin
        q_o[i] <= s3[i];
      end
    end
  end

endmodule

//--- tb/tb.sv
/*
  Self-checking bench of the tape command decoder: register-port tasks,
  rewind, clear and list scenarios against the far-side model.
  Assumes the package, the decoder and tcd_far_model are compiled first.
*/
`timescale 1ns/1ps
module tb import tcd_pkg::*;;
  localparam int ER = 20;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic hold = 1'h0;
  logic mark = 1'h0;
  logic [3:0] ack_dly = 4'h0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o, list_addr_o, mem_word_o, status_o;
  logic [2:0] rewind_o, unload_o, rw_acc, ul_acc;
  logic list_req_o, data_req_o, mem_wr_o, irq_o, status_req_o, status_ack_i, busy_o;
  logic irq_pend, dir_seen, lr_prev;
  tcd_tape_in_t tape_i;
  tcd_tape_out_t tape_o;
  logic [15:0] st_q[$], mem_q[$];
  logic [7:0] wc_q[$];
  logic si_q[$];
  int er_n, lr_n;
  int cyc = 0;
  int miscompares = 0;
  int tests_run = 0;
  tcd_fn_t fns[3] = '{FN_RW_INT, FN_RW_UNLOAD, FN_RW_QUIET};
  logic [2:0] subs[5] = '{SUB_READ, SUB_WRITE, 3'h2, 3'h3, 3'h7};

  always #2.5 clk_i = ~clk_i;

  tcd_decoder #(.ERASE_CYC(ER)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'h1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tape_i(tape_i), .tape_o(tape_o), .rewind_o(rewind_o), .unload_o(unload_o),
    .list_req_o(list_req_o), .list_addr_o(list_addr_o), .data_req_o(data_req_o),
    .mem_word_o(mem_word_o), .mem_wr_o(mem_wr_o), .irq_o(irq_o),
    .status_req_o(status_req_o), .status_o(status_o),
    .status_ack_i(status_ack_i), .busy_o(busy_o)
  );

  tcd_far_model u_far (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .drv_i(tape_o), .rewind_i(rewind_o),
    .status_req_i(status_req_o), .hold_i(hold), .mark_i(mark),
    .ack_dly_i(ack_dly), .tape_o(tape_i), .status_ack_o(status_ack_i)
  );

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    @(posedge clk_i);
    d = rdata_o;
  endtask

  task automatic clr();
    st_q.delete();
    si_q.delete();
    mem_q.delete();
    wc_q.delete();
    {rw_acc, ul_acc, irq_pend, dir_seen, lr_prev} = '0;
    er_n = 0;
    lr_n = 0;
  endtask

  // Printed bit 10 is left at zero in every command.
  function automatic logic [15:0] act(input logic [1:0] fn, input logic [1:0] sel);
    logic [15:0] w;
    w = 16'h0000;
    w[AW_FN_HI:AW_FN_LO] = fn;
    w[AW_SEL_HI:AW_SEL_LO] = sel;
    return w;
  endfunction

  function automatic logic [15:0] l3(input logic ie, input logic dir, input logic [2:0] sub);
    logic [15:0] w;
    w = 16'h0000;
    w[L3_INT] = ie;
    w[L3_DIR] = dir;
    w[L3_SUB_HI:L3_SUB_LO] = sub;
    return w;
  endfunction

  task automatic chk_st(input int p, input int b, input logic ie);
    chk({15'h0, st_q[p][b]}, 16'h0001);
    chk({15'h0, si_q[p]}, {15'h0, ie});
  endtask

  task automatic run_list(input logic [15:0] w3, input logic [15:0] cnt, input int nd);
    int k;
    k = 0;
    clr();
    wr(REG_ACT1, act(FN_LIST, SEL_T1));
    for (int i = 0; i < 200 && list_req_o !== 1'h1; i++) @(posedge clk_i);
    wr(REG_LW1, 16'h0200);
    wr(REG_LW2, cnt);
    wr(REG_LW4, 16'h0300);
    wr(REG_LW3, w3);
    for (int i = 0; i < 3000 && busy_o !== 1'h0; i++) begin
      if (data_req_o === 1'h1 && k < nd) begin
        wr(REG_DATA, 16'h4142 + 16'(k) * 16'h0202);
        k++;
        @(posedge clk_i);
      end else begin
        @(posedge clk_i);
      end
    end
    tick(3);
    chk(16'(st_q.size()), 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
    if (rst_n_i) begin
      if (irq_o)
        irq_pend = 1'h1;
      if (status_req_o && status_ack_i) begin
        chk({15'h0, busy_o}, 16'h0001);
        st_q.push_back(status_o);
        si_q.push_back(irq_pend);
        irq_pend = 1'h0;
      end
      if (mem_wr_o)
        mem_q.push_back(mem_word_o);
      if (tape_o.wstb)
        wc_q.push_back(tape_o.wchr);
      if (tape_o.erase)
        er_n++;
      if (tape_o.motion && tape_o.dir)
        dir_seen = 1'h1;
      if (list_req_o && !lr_prev)
        lr_n++;
      lr_prev = list_req_o;
      rw_acc |= rewind_o;
      ul_acc |= unload_o;
    end
  end

  initial begin
    logic [15:0] d;
    clr();
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    rd(3'h7, d);
    chk(d, 16'h0000);
    rd(REG_ACT1, d);
    chk(d & 16'he001, 16'h0000);
    for (int u = 0; u < 3; u++) begin
      clr();
      wr(REG_ACT1, act(fns[u], 2'(u + 1)));
      tick(2);
      chk({13'h0, rw_acc}, 16'(1 << u));
      for (int i = 0; i < 400 && st_q.size() < 2; i++) @(posedge clk_i);
      chk_st(0, ST_OC, fns[u] != FN_RW_QUIET);
      if (fns[u] == FN_RW_UNLOAD) begin
        chk({13'h0, ul_acc}, 16'(1 << u));
        chk(16'(st_q.size()), 16'h0001);
      end else begin
        chk_st(1, ST_RW_BASE - u, fns[u] == FN_RW_INT);
      end
    end
    // Hold the acknowledge so the controller sits busy on a pending store.
    clr();
    hold <= 1'h1;
    wr(REG_ACT1, act(FN_RW_INT, SEL_T1));
    for (int i = 0; i < 50 && status_req_o !== 1'h1; i++) @(posedge clk_i);
    wr(REG_ACT1, act(FN_RW_QUIET, SEL_T2));
    rd(REG_ACT1, d);
    chk({15'h0, d[0]}, 16'h0001);
    chk({13'h0, rw_acc}, 16'h0001);
    wr(REG_ACT1, act(FN_RW_INT, SEL_CLEAR));
    chk({15'h0, status_req_o}, 16'h0000);
    clr();
    ack_dly <= 4'h6;
    hold <= 1'h0;
    wr(REG_ACT1, act(FN_RW_QUIET, 2'h3));
    for (int i = 0; i < 400 && st_q.size() < 2; i++) @(posedge clk_i);
    chk({13'h0, rw_acc}, 16'h0004);
    chk_st(0, ST_OC, 1'h0);
    tick(20);
    run_list(l3(1'h1, 1'h1, SUB_READ), 16'h0003, 0);
    chk(mem_q[0], 16'ha0a1);
    chk(mem_q[1], 16'ha2ff);
    chk({15'h0, dir_seen}, 16'h0000);
    chk_st(0, ST_OC, 1'h1);
    chk(16'(lr_n), 16'h0001);
    chk(list_addr_o, 16'h0300);
    rd(REG_LW1, d);
    chk(d, 16'h0200);
    rd(REG_CNT, d);
    chk(d, 16'h0000);
    run_list(l3(1'h0, 1'h1, SUB_WRITE), 16'h0003, 2);
    chk(16'(wc_q.size()), 16'h0003);
    for (int i = 0; i < 3; i++) chk({8'h00, wc_q[i]}, 16'h0041 + 16'(i));
    chk({15'h0, dir_seen}, 16'h0000);
    chk_st(0, ST_OC, 1'h0);
    foreach (subs[j]) begin
      run_list(l3(1'(j), 1'h0, subs[j]), 16'h0000, 0);
      chk(16'(wc_q.size() + mem_q.size() + er_n), 16'h0000);
      chk_st(0, ST_OC, 1'(j));
    end
    run_list(l3(1'h1, 1'h1, SUB_ERASE), 16'h0000, 0);
    chk(16'(er_n), 16'(ER));
    chk({15'h0, dir_seen}, 16'h0000);
    run_list(l3(1'h0, 1'h1, SUB_WEOF), 16'h0000, 0);
    chk(16'(er_n), 16'(ER));
    chk({8'h00, wc_q[0]}, {8'h00, EOF_CHAR});
    mark <= 1'h1;
    run_list(l3(1'h0, 1'h1, SUB_SKIP), 16'h0000, 0);
    chk_st(0, ST_EOF, 1'h0);
    chk({15'h0, dir_seen}, 16'h0001);
    mark <= 1'h0;
    // A chained zero-count read asks for the next list and stores no status.
    clr();
    wr(REG_ACT1, act(FN_LIST, SEL_T1));
    wr(REG_LW2, 16'h0000);
    wr(REG_LW3, l3(1'h0, 1'h0, SUB_READ) | 16'(1 << L3_CHAIN));
    tick(3);
    chk(16'(lr_n), 16'h0002);
    chk(16'(st_q.size()), 16'h0000);
    wr(REG_LW3, l3(1'h0, 1'h0, 3'h7) | 16'(1 << L3_CHAIN));
    tick(30);
    chk(16'(lr_n), 16'h0002);
    chk(16'(st_q.size()), 16'h0001);
    tick(4);
    finish_test();
  end
endmodule

//--- tb/tcd_far_model.sv
/*
  Far-side model: three tape transports and the status acknowledge of the
  block-transfer section.
  Assumes the decoder's clock; the bench steers ack delay, ack hold and file mark.
*/
`timescale 1ns/1ps
module tcd_far_model import tcd_pkg::*; #(
  parameter int REC_LEN = 6,
  parameter int RW_DLY = 40
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire tcd_tape_out_t drv_i,
  input wire logic [2:0] rewind_i,
  input wire logic status_req_i,
  input wire logic hold_i,
  input wire logic mark_i,
  input wire logic [3:0] ack_dly_i,
  output tcd_tape_in_t tape_o,
  output logic status_ack_o
);
  logic [7:0] chr;
  logic stb, gap, mark;
  logic [2:0] sot;
  int ph, nchr, ack_cnt;
  int rw_cnt [3];

  assign tape_o = {chr, stb, gap, mark, sot};

  ////////////////////////////////////////////////////////////////
  // One character every 12 cycles while moving, up to REC_LEN per motion. Between strobes the data
  // lines toggle, so a stale character can never pass for a fresh one.
  always @(posedge clk_i) begin
    if (!rst_n_i || !drv_i.motion) begin
      ph <= 0;
      nchr <= 0;
      stb <= 1'h0;
      gap <= 1'h0;
      mark <= 1'h0;
      chr <= rst_n_i ? ~chr : 8'h5a;
    end else begin
      ph <= (ph + 1) % 12;
      if (!stb)
        chr <= ~chr;
      if (ph == 8 && nchr < REC_LEN) begin
        chr <= 8'ha0 + 8'(nchr);
        stb <= 1'h1;
        nchr <= nchr + 1;
      end else if (ph == 2) begin
        stb <= 1'h0;
      end
      if (ph == 5 && nchr == REC_LEN) begin
        gap <= !mark_i;
        mark <= mark_i;
      end
    end
  end

  always @(posedge clk_i) begin
    for (int u = 0; u < 3; u++) begin
      if (!rst_n_i) begin
        rw_cnt[u] <= 0;
        sot[u] <= 1'h0;
      end else if (rewind_i[u]) begin
        rw_cnt[u] <= RW_DLY;
        sot[u] <= 1'h0;
      end else if (rw_cnt[u] > 0) begin
        rw_cnt[u] <= rw_cnt[u] - 1;
        sot[u] <= (rw_cnt[u] == 1);
      end
    end
  end

  always @(posedge clk_i) begin
    status_ack_o <= 1'h0;
    if (!rst_n_i || !status_req_i || hold_i || status_ack_o) begin
      ack_cnt <= 0;
    end else if (ack_cnt == int'(ack_dly_i)) begin
      status_ack_o <= 1'h1;
    end else begin
      ack_cnt <= ack_cnt + 1;
    end
  end
endmodule
